// ===== phi_pkg.sv
// Package of constants for the printer host input lines block
package phi_pkg;
    // ************************************************************
    // Widths and levels
    // ************************************************************
    localparam int unsigned DATA_W = 12;
    localparam int unsigned STROBE_N = 4;
    localparam int unsigned READY_N = 5;
    localparam logic LOW_TRUE_LEVEL = 1'h0;
    localparam logic HIGH_FALSE_LEVEL = 1'h1;
    // Strobe index order
    localparam int unsigned STB_CARRIAGE = 0;
    localparam int unsigned STB_PAPER = 1;
    localparam int unsigned STB_WHEEL = 2;
    localparam int unsigned STB_OPTION = 3;
    localparam logic [STROBE_N-1:0] STROBE_NONE = 4'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 12'h000;
    localparam logic [READY_N-1:0] READY_ZERO = 5'h00;
endpackage : phi_pkg

// ===== phi_sync_if.sv
// Interface carrying raw and synchronised low-true pin levels through the sync stage
`timescale 1ns/10ps
interface phi_sync_if;
    logic [phi_pkg::DATA_W+phi_pkg::STROBE_N+2:0] raw;
    logic [phi_pkg::DATA_W+phi_pkg::STROBE_N+2:0] synced;
    modport sync_side (input raw, output synced);
    modport user_side (output raw, input synced);
endinterface : phi_sync_if

// ===== phi_sync.sv
// Two-stage synchroniser bank for asynchronous pins
`timescale 1ns/10ps
module phi_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Bundle
    phi_sync_if.sync_side sif
);
    logic [phi_pkg::DATA_W+phi_pkg::STROBE_N+2:0] stage1;
    logic [phi_pkg::DATA_W+phi_pkg::STROBE_N+2:0] stage2;

    // Pins idle high (false), so reset to all ones
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage1 <= '1;
            stage2 <= '1;
        end else begin
            stage1 <= sif.raw;
            stage2 <= stage1;
        end
    end

    assign sif.synced = stage2;
endmodule : phi_sync

// ===== phi_top.sv
// Printer host input lines: select gating, strobes, restore, ribbon lift
`timescale 1ns/10ps
module phi_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Host pins, all low-true
    input wire logic select_n_i,
    input wire logic [phi_pkg::STROBE_N-1:0] strobe_n_i,
    input wire logic restore_n_i,
    input wire logic ribbon_lift_n_i,
    input wire logic [phi_pkg::DATA_W-1:0] data_n_i,
    // Ready status from printer core, true high
    input wire logic [phi_pkg::READY_N-1:0] ready_i,
    // Ready pins toward host, low-true, open drain style
    output logic [phi_pkg::READY_N-1:0] ready_n_o,
    output logic [phi_pkg::READY_N-1:0] ready_oe_o,
    // Commands toward printer core
    output logic [phi_pkg::STROBE_N-1:0] start_o,
    output logic [phi_pkg::DATA_W-1:0] cmd_data_o,
    output logic restore_o,
    output logic ribbon_up_o
);
    // ************************************************************
    // Synchronisers
    // ************************************************************
    phi_sync_if sif ();

    assign sif.raw = {select_n_i, restore_n_i, ribbon_lift_n_i, strobe_n_i, data_n_i};

    phi_sync u_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .sif(sif)
    );

    // ************************************************************
    // True-level decode
    // ************************************************************
    function automatic logic is_true(input logic pin_level);
        is_true = (pin_level == phi_pkg::LOW_TRUE_LEVEL);
    endfunction : is_true

    localparam int unsigned SEL_BIT = phi_pkg::DATA_W + phi_pkg::STROBE_N + 2;
    localparam int unsigned RST_BIT = phi_pkg::DATA_W + phi_pkg::STROBE_N + 1;
    localparam int unsigned RIB_BIT = phi_pkg::DATA_W + phi_pkg::STROBE_N;

    logic sel;
    logic restore_req;
    logic ribbon_req;
    logic [phi_pkg::STROBE_N-1:0] strobe_req;
    logic [phi_pkg::DATA_W-1:0] data_true;

    assign sel = is_true(sif.synced[SEL_BIT]);
    assign restore_req = is_true(sif.synced[RST_BIT]);
    assign ribbon_req = is_true(sif.synced[RIB_BIT]);
    assign data_true = ~sif.synced[phi_pkg::DATA_W-1:0];

    genvar gi;
    generate
        for (gi = 0; gi < phi_pkg::STROBE_N; gi++) begin : g_stb
            assign strobe_req[gi] = is_true(sif.synced[phi_pkg::DATA_W+gi]);
        end
    endgenerate

    // ************************************************************
    // Edge detection
    // ************************************************************
    // Previous levels are gated by select, so a strobe held while select
    // rises counts as a fresh assertion; trade-off keeps select authoritative.
    logic [phi_pkg::STROBE_N-1:0] strobe_prev;
    logic restore_prev;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strobe_prev <= phi_pkg::STROBE_NONE;
            restore_prev <= 1'h0;
        end else begin
            strobe_prev <= strobe_req & {phi_pkg::STROBE_N{sel}};
            restore_prev <= restore_req & sel;
        end
    end

    logic [phi_pkg::STROBE_N-1:0] next_start;
    logic next_restore;

    assign next_start = strobe_req & ~strobe_prev & {phi_pkg::STROBE_N{sel}};
    assign next_restore = restore_req & ~restore_prev & sel;

    // ************************************************************
    // Command outputs
    // ************************************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            start_o <= phi_pkg::STROBE_NONE;
            cmd_data_o <= phi_pkg::DATA_ZERO;
        end else begin
            start_o <= next_start;
            if (|next_start) begin
                cmd_data_o <= data_true;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            restore_o <= 1'h0;
        end else begin
            restore_o <= next_restore;
        end
    end

    // Ribbon holds its last position while deselected
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ribbon_up_o <= 1'h0;
        end else if (sel) begin
            ribbon_up_o <= ribbon_req;
        end
    end

    // ************************************************************
    // Ready status drive
    // ************************************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ready_oe_o <= phi_pkg::READY_ZERO;
            ready_n_o <= ~phi_pkg::READY_ZERO;
        end else begin
            ready_oe_o <= {phi_pkg::READY_N{sel}};
            ready_n_o <= ~ready_i;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_strobe_fall(int k);
        $fell(sif.synced[phi_pkg::DATA_W+k]) && sel;
    endsequence

    // Judged from the pin itself, three edges back, so a broken synchroniser shows up too
    property p_ready_gated;
        @(posedge clk_i) disable iff (!arst_n_i)
        ready_oe_o == {phi_pkg::READY_N{!$past(select_n_i, 3)}};
    endproperty
    a_ready_gated: assert property (p_ready_gated) else $error("ready drive not tied to select");

    property p_no_start_deselected;
        @(posedge clk_i) disable iff (!arst_n_i)
        !sel |=> (start_o == phi_pkg::STROBE_NONE) && !restore_o;
    endproperty
    a_no_start_deselected: assert property (p_no_start_deselected) else $error("activity while deselected");

    property p_carriage_start;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_strobe_fall(phi_pkg::STB_CARRIAGE) |=> start_o[phi_pkg::STB_CARRIAGE] ##1 !start_o[phi_pkg::STB_CARRIAGE];
    endproperty
    a_carriage_start: assert property (p_carriage_start) else $error("carriage start missing");

    property p_paper_start;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_strobe_fall(phi_pkg::STB_PAPER) |=> start_o[phi_pkg::STB_PAPER];
    endproperty
    a_paper_start: assert property (p_paper_start) else $error("paper feed start missing");

    property p_option_start;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_strobe_fall(phi_pkg::STB_OPTION) |=> start_o[phi_pkg::STB_OPTION];
    endproperty
    a_option_start: assert property (p_option_start) else $error("option start missing");

    property p_wheel_start;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_strobe_fall(phi_pkg::STB_WHEEL) |=> start_o[phi_pkg::STB_WHEEL];
    endproperty
    a_wheel_start: assert property (p_wheel_start) else $error("print wheel start missing");

    property p_start_pulse;
        @(posedge clk_i) disable iff (!arst_n_i)
        |start_o |=> ((start_o & $past(start_o)) == phi_pkg::STROBE_NONE);
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");

    property p_restore;
        @(posedge clk_i) disable iff (!arst_n_i)
        ($fell(sif.synced[RST_BIT]) && sel) |=> restore_o ##1 !restore_o;
    endproperty
    a_restore: assert property (p_restore) else $error("restore pulse wrong");

    property p_ribbon_up;
        @(posedge clk_i) disable iff (!arst_n_i)
        (sel && !sif.synced[RIB_BIT]) |=> ribbon_up_o;
    endproperty
    a_ribbon_up: assert property (p_ribbon_up) else $error("ribbon not raised");

    property p_ribbon_down;
        @(posedge clk_i) disable iff (!arst_n_i)
        (sel && sif.synced[RIB_BIT]) |=> !ribbon_up_o;
    endproperty
    a_ribbon_down: assert property (p_ribbon_down) else $error("ribbon not down");

    property p_data_capture;
        @(posedge clk_i) disable iff (!arst_n_i)
        (|next_start) |=> cmd_data_o == ~$past(sif.synced[phi_pkg::DATA_W-1:0]);
    endproperty
    a_data_capture: assert property (p_data_capture) else $error("command word not inverted or latched");

    property p_data_hold;
        @(posedge clk_i) disable iff (!arst_n_i)
        !(|next_start) |=> $stable(cmd_data_o);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("command word changed without strobe");
endmodule : phi_top

// ===== phi_host_model.sv
// Host controller model that drives the low-true printer pins
`timescale 1ns/10ps
module phi_host_model (
    // Clock
    input wire logic clk_i,
    // Host pins, low-true
    output logic select_n_o,
    output logic [phi_pkg::STROBE_N-1:0] strobe_n_o,
    output logic restore_n_o,
    output logic ribbon_lift_n_o,
    output logic [phi_pkg::DATA_W-1:0] data_n_o
);
    // ************************************************************
    // Idle pins set at time zero; pin tasks change pins at the falling edge
    // ************************************************************
    initial begin
        select_n_o = phi_pkg::HIGH_FALSE_LEVEL;
        strobe_n_o = ~phi_pkg::STROBE_NONE;
        restore_n_o = phi_pkg::HIGH_FALSE_LEVEL;
        ribbon_lift_n_o = phi_pkg::HIGH_FALSE_LEVEL;
        data_n_o = ~phi_pkg::DATA_ZERO;
    end
    task automatic set_select(input logic on);
        @(negedge clk_i);
        select_n_o = ~on;
    endtask : set_select
    task automatic set_ribbon(input logic up);
        @(negedge clk_i);
        ribbon_lift_n_o = ~up;
    endtask : set_ribbon
    // Word is set before the strobe falls; afterwards it is inverted so a stale latch shows up
    task automatic strobe(input int unsigned idx, input logic [phi_pkg::DATA_W-1:0] word);
        @(negedge clk_i);
        data_n_o = ~word;
        @(negedge clk_i);
        strobe_n_o[idx] = phi_pkg::LOW_TRUE_LEVEL;
        repeat (4) @(negedge clk_i);
        strobe_n_o[idx] = phi_pkg::HIGH_FALSE_LEVEL;
        @(negedge clk_i);
        data_n_o = word;
        repeat (2) @(negedge clk_i);
    endtask : strobe
    // Carriage return is sent with the carriage strobe, never with this task
    task automatic restore_pulse();
        @(negedge clk_i);
        restore_n_o = phi_pkg::LOW_TRUE_LEVEL;
        repeat (4) @(negedge clk_i);
        restore_n_o = phi_pkg::HIGH_FALSE_LEVEL;
        repeat (2) @(negedge clk_i);
    endtask : restore_pulse
endmodule : phi_host_model

// ===== testbench.sv
// Self-checking testbench for the printer host input lines
`timescale 1ns/10ps
module testbench;
    logic clk_i, arst_n_i, select_n, restore_n, ribbon_n, restore_o, ribbon_up_o;
    logic [phi_pkg::STROBE_N-1:0] strobe_n, start_o;
    logic [phi_pkg::DATA_W-1:0] data_n, cmd_data_o;
    logic [phi_pkg::READY_N-1:0] ready_i, ready_n_o, ready_oe_o;
    int error_cnt = 0;
    int cmp_count = 0;
    int start_cnt[4] = '{default: 0};
    int restore_cnt = 0;
    phi_host_model host (.clk_i(clk_i), .select_n_o(select_n), .strobe_n_o(strobe_n), .restore_n_o(restore_n),
        .ribbon_lift_n_o(ribbon_n), .data_n_o(data_n));
    phi_top DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .select_n_i(select_n), .strobe_n_i(strobe_n),
        .restore_n_i(restore_n), .ribbon_lift_n_i(ribbon_n), .data_n_i(data_n), .ready_i(ready_i),
        .ready_n_o(ready_n_o), .ready_oe_o(ready_oe_o), .start_o(start_o), .cmd_data_o(cmd_data_o),
        .restore_o(restore_o), .ribbon_up_o(ribbon_up_o));
    // ************************************************************
    // Clock, pulse counters and compare tasks
    // ************************************************************
    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end
    // Counting every high cycle means a stretched pulse shows up as an extra count
    always @(posedge clk_i) begin
        for (int k = 0; k < 4; k++) if (start_o[k] === 1'h1) start_cnt[k]++;
        if (restore_o === 1'h1) restore_cnt++;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_n(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t count got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_n
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_deselected();
        for (int i = 0; i < 4; i++) host.strobe(i, 12'hFFF);
        host.restore_pulse();
        host.set_ribbon(1'h1);
        repeat (4) @(negedge clk_i);
        for (int i = 0; i < 4; i++) chk_n(start_cnt[i], 0);
        chk_n(restore_cnt, 0);
        chk(ribbon_up_o, 16'h0000);
        chk(ready_oe_o, 16'h0000);
        chk(cmd_data_o, 16'h0000);
        host.set_ribbon(1'h0);
    endtask : t_deselected
    task automatic t_select_ready();
        host.set_select(1'h1);
        for (int v = 0; v < phi_pkg::READY_N; v++) begin
            ready_i = 5'h01 << v;
            repeat (4) @(negedge clk_i);
            chk(ready_oe_o, 16'h001F);
            chk(ready_n_o, ~(16'h0001 << v) & 16'h001F);
        end
        ready_i = 5'h15;
        repeat (4) @(negedge clk_i);
        chk(ready_oe_o, 16'h001F);
        chk(ready_n_o, 16'h000A);
    endtask : t_select_ready
    task automatic t_strobes();
        logic [11:0] word;
        for (int i = 0; i < 4; i++) begin
            word = 12'hC35 ^ (12'h101 << i);
            host.strobe(i, word);
            repeat (3) @(negedge clk_i);
            chk_n(start_cnt[i], 1);
            chk({4'h0, cmd_data_o}, {4'h0, word});
        end
    endtask : t_strobes
    task automatic t_restore();
        host.restore_pulse();
        repeat (3) @(negedge clk_i);
        chk_n(restore_cnt, 1);
        chk_n(start_cnt[phi_pkg::STB_CARRIAGE], 1);
    endtask : t_restore
    task automatic t_ribbon();
        host.set_ribbon(1'h1);
        repeat (4) @(negedge clk_i);
        chk(ribbon_up_o, 16'h0001);
        host.set_ribbon(1'h0);
        repeat (4) @(negedge clk_i);
        chk(ribbon_up_o, 16'h0000);
        host.set_ribbon(1'h1);
        repeat (4) @(negedge clk_i);
        host.set_select(1'h0);
        repeat (4) @(negedge clk_i);
        host.set_ribbon(1'h0);
        host.strobe(phi_pkg::STB_OPTION, 12'h0F0);
        repeat (3) @(negedge clk_i);
        chk(ribbon_up_o, 16'h0001);
        chk_n(start_cnt[phi_pkg::STB_OPTION], 1);
        chk(ready_oe_o, 16'h0000);
    endtask : t_ribbon
    // Second reset in mid-run while deselected with the ribbon held up
    task automatic t_reset_mid();
        ready_i = 5'h0A;
        @(negedge clk_i);
        arst_n_i = 1'h0;
        repeat (2) @(negedge clk_i);
        chk({ribbon_up_o, cmd_data_o}, 16'h0000);
        chk(ready_n_o, 16'h001F);
        arst_n_i = 1'h1;
        repeat (4) @(negedge clk_i);
        chk(ready_n_o, 16'h0015);
        chk(ready_oe_o, 16'h0000);
        chk_n(start_cnt[phi_pkg::STB_OPTION] + restore_cnt, 2);
    endtask : t_reset_mid
    initial begin
        arst_n_i = 1'h0;
        ready_i = 5'h00;
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        chk(ready_n_o, 16'h001F);
        chk({start_o, restore_o, ribbon_up_o}, 16'h0000);
        arst_n_i = 1'h1;
        repeat (3) @(negedge clk_i);
        t_deselected();
        t_select_ready();
        t_strobes();
        t_restore();
        t_ribbon();
        t_reset_mid();
        finish_test();
    end
    // Whole run is well under 1000 cycles; this limit leaves ample slack
    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end
endmodule : testbench
